// ==== rtl/i2c_address_and_rate_timing.sv ====
// two-wire own address holding, bit rate generation and timed start, byte and stop
//
// What this block does
// - own slave address sits in address register bits 7..1 and drives compares.
// - stored address is the whole 7-bit address or low seven of 10-bit.
// - multiplier field bits 7..6 selects factor 1, 2, 4; code 11 reserved.
// - rate code bits 5..0 looks up SCL divider and three hold values.
// - bit rate equals bus clock over multiplier times SCL divider.
// - after SCL falls, wait multiplier times SDA hold before changing SDA.
// - start holds SCL high multiplier times start hold after SDA falls.
// - stop lets SDA rise multiplier times stop hold after SCL rises.
// - codes 0x00..0x0F use the first sixteen divider values.
// - codes 0x10..0x1F use the next sixteen divider values.
// - SDA hold values follow the fixed table for codes 0x00..0x1F.
// - stop hold is half divider plus one; start hold half minus offset.
`timescale 1ns/10ps
module i2c_address_and_rate_timing (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	input  wire logic [7:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	input  wire logic [3:0]  i_byteenable,
	output logic      [31:0] o_readdata,
	output logic             o_waitrequest,
	input  wire logic        i_scl,
	output logic             o_scl,
	output logic             o_scl_oe_n,
	input  wire logic        i_sda,
	output logic             o_sda,
	output logic             o_sda_oe_n,
	output logic             o_busy,
	output logic             o_addr_match
);

	// ************************************************************
	// state and reset value
	// ************************************************************
	localparam i2c_rate_pkg::main_state_t RST = '{
		waitreq:   1'b1,
		rdata:     32'h0000_0000,
		own_addr:  i2c_rate_pkg::OWN_ADDR_RST,
		rate_multiplier_sel:      i2c_rate_pkg::RATE_MULTIPLIER_SEL_RST,
		clock_rate_code:       i2c_rate_pkg::ICR_RST,
		ten_en:    1'b0,
		hi_addr:   3'h0,
		st:        i2c_rate_pkg::ST_IDLE,
		cnt:       14'h0000,
		bitn:      4'h0,
		shift:     8'h00,
		stop_pend: 1'b0,
		scl_oe_n:  1'b1,
		sda_oe_n:  1'b1,
		pin_lvl:   1'b0,
		nack:      1'b0,
		held:      1'b0,
		busy:      1'b0};

	i2c_rate_pkg::main_state_t q;
	i2c_rate_pkg::main_state_t d;
	i2c_rate_pkg::rate_t       tm;
	logic [31:0]               rd_val;
	logic [13:0]               half_lo;
	logic [13:0]               half_hi;
	logic                      go;
	logic                      go_start;
	logic                      go_stop;
	logic                      match;

	// ************************************************************
	// helpers
	// ************************************************************
	rate_lookup u_rate (
		.i_code (q.clock_rate_code),
		.i_rate_multiplier_sel (q.rate_multiplier_sel),
		.o_tm   (tm)
	);

	addr_match u_match (
		.i_clk      (i_clk),
		.i_rst_n    (i_rst_n),
		.i_ce       (i_ce),
		.i_scl      (i_scl),
		.i_sda      (i_sda),
		.i_own_addr (q.own_addr),
		.i_ten_en   (q.ten_en),
		.i_hi_addr  (q.hi_addr),
		.o_match    (match)
	);

	// ************************************************************
	// register read mux
	// ************************************************************
	always_comb begin
		unique case (i_address)
			i2c_rate_pkg::OFS_OWN_ADDR: begin
				rd_val = {24'h00_0000, q.own_addr, 1'b0};
			end
			i2c_rate_pkg::OFS_RATE_DIV: begin
				rd_val = {24'h00_0000, q.rate_multiplier_sel, q.clock_rate_code};
			end
			i2c_rate_pkg::OFS_XFER: begin
				rd_val = {22'h00_0000, q.stop_pend, 1'b0, q.shift};
			end
			i2c_rate_pkg::OFS_STATUS: begin
				rd_val = {28'h000_0000, q.held, match, q.nack, q.busy};
			end
			i2c_rate_pkg::OFS_CTRL: begin
				rd_val = {28'h000_0000, q.hi_addr, q.ten_en};
			end
			default: begin
				rd_val = 32'h0000_0000;
			end
		endcase
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		d        = q;
		go       = 1'b0;
		go_start = i_writedata[i2c_rate_pkg::XFER_START] & i_byteenable[1];
		go_stop  = i_writedata[i2c_rate_pkg::XFER_STOP] & i_byteenable[1];
		half_lo  = tm.period >> 1;
		half_hi  = tm.period - half_lo;

		// one wait cycle, then the answer stands for one cycle
		if (q.waitreq) begin
			if (i_read || i_write) begin
				d.waitreq = 1'b0;
				d.rdata   = rd_val;
			end
		end else begin
			d.waitreq = 1'b1;
			if (i_write && i_byteenable[0]) begin
				unique case (i_address)
					i2c_rate_pkg::OFS_OWN_ADDR: begin
						d.own_addr = i_writedata[i2c_rate_pkg::ADDR_LSB +: 7];
					end
					i2c_rate_pkg::OFS_RATE_DIV: begin
						d.rate_multiplier_sel = i_writedata[i2c_rate_pkg::RATE_MULTIPLIER_SEL_LSB +: 2];
						d.clock_rate_code  = i_writedata[5:0];
					end
					i2c_rate_pkg::OFS_CTRL: begin
						d.ten_en  = i_writedata[i2c_rate_pkg::CTRL_TEN_EN];
						d.hi_addr = i_writedata[i2c_rate_pkg::CTRL_HI_LSB +: 3];
					end
					i2c_rate_pkg::OFS_XFER: begin
						// a launch while busy is dropped, not queued
						go = q.st == i2c_rate_pkg::ST_IDLE;
					end
					default: begin
					end
				endcase
			end
		end

		unique case (q.st)
			i2c_rate_pkg::ST_IDLE: begin
				if (go) begin
					d.shift     = i_writedata[7:0];
					d.stop_pend = go_stop;
					d.nack      = 1'b0;
					d.cnt       = 14'h0000;
					d.bitn      = 4'h0;
					if (go_start && q.held) begin
						d.bitn = i2c_rate_pkg::BIT_RESTART;
						d.st   = i2c_rate_pkg::ST_LOW;
					end else if (go_start) begin
						d.st = i2c_rate_pkg::ST_START;
					end else begin
						d.st = i2c_rate_pkg::ST_LOW;
					end
					d.held = 1'b0;
				end
			end
			i2c_rate_pkg::ST_START: begin
				// wait for a free bus before pulling data low
				if (q.sda_oe_n) begin
					if (i_scl && i_sda) begin
						d.sda_oe_n = 1'b0;
						d.cnt      = 14'h0000;
					end
				end else if (q.cnt >= tm.start - 14'h0001) begin
					d.scl_oe_n = 1'b0;
					d.cnt      = 14'h0000;
					d.bitn     = 4'h0;
					d.st       = i2c_rate_pkg::ST_LOW;
				end else begin
					d.cnt = q.cnt + 14'h0001;
				end
			end
			i2c_rate_pkg::ST_LOW: begin
				d.cnt = q.cnt + 14'h0001;
				if (q.cnt == tm.sda - 14'h0001) begin
					unique case (q.bitn)
						i2c_rate_pkg::BIT_ACK:     d.sda_oe_n = 1'b1;
						i2c_rate_pkg::BIT_STOP:    d.sda_oe_n = 1'b0;
						i2c_rate_pkg::BIT_RESTART: d.sda_oe_n = 1'b1;
						default:                   d.sda_oe_n = q.shift[7];
					endcase
				end
				if (q.cnt == half_lo - 14'h0001) begin
					d.scl_oe_n = 1'b1;
					d.cnt      = 14'h0000;
					d.st       = (q.bitn == i2c_rate_pkg::BIT_STOP) ?
						i2c_rate_pkg::ST_STOP : i2c_rate_pkg::ST_HIGH;
				end
			end
			i2c_rate_pkg::ST_HIGH: begin
				// a slave stretching the clock freezes the high count
				if (i_scl) begin
					d.cnt = q.cnt + 14'h0001;
					if (q.cnt == 14'h0000 && q.bitn == i2c_rate_pkg::BIT_ACK) begin
						d.nack = i_sda;
					end
					if (q.cnt == half_hi - 14'h0001) begin
						d.cnt = 14'h0000;
						if (q.bitn == i2c_rate_pkg::BIT_RESTART) begin
							d.st = i2c_rate_pkg::ST_START;
						end else if (q.bitn == i2c_rate_pkg::BIT_ACK) begin
							d.scl_oe_n = 1'b0;
							if (q.stop_pend) begin
								d.bitn = i2c_rate_pkg::BIT_STOP;
								d.st   = i2c_rate_pkg::ST_LOW;
							end else begin
								d.held = 1'b1;
								d.st   = i2c_rate_pkg::ST_IDLE;
							end
						end else begin
							d.scl_oe_n = 1'b0;
							d.bitn     = q.bitn + 4'h1;
							d.shift    = {q.shift[6:0], 1'b0};
							d.st       = i2c_rate_pkg::ST_LOW;
						end
					end
				end
			end
			i2c_rate_pkg::ST_STOP: begin
				if (i_scl) begin
					d.cnt = q.cnt + 14'h0001;
					if (q.cnt == tm.stop - 14'h0001) begin
						d.sda_oe_n = 1'b1;
						d.cnt      = 14'h0000;
						d.st       = i2c_rate_pkg::ST_IDLE;
					end
				end
			end
		endcase
		d.busy = d.st != i2c_rate_pkg::ST_IDLE;
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= RST;
		end else if (i_ce) begin
			q <= d;
		end
	end

	assign o_readdata    = q.rdata;
	assign o_waitrequest = q.waitreq;
	assign o_scl         = q.pin_lvl;
	assign o_scl_oe_n    = q.scl_oe_n;
	assign o_sda         = q.pin_lvl;
	assign o_sda_oe_n    = q.sda_oe_n;
	assign o_busy        = q.busy;
	assign o_addr_match  = match;
endmodule // i2c_address_and_rate_timing

// ==== rtl/i2c_rate_pkg.sv ====
// shared constants, tables and state types for the two-wire address and rate block
package i2c_rate_pkg;

	// ************************************************************
	// register map and field positions
	// ************************************************************
	localparam logic [7:0] OFS_OWN_ADDR  = 8'h00;
	localparam logic [7:0] OFS_RATE_DIV  = 8'h04;
	localparam logic [7:0] OFS_XFER      = 8'h08;
	localparam logic [7:0] OFS_STATUS    = 8'h0C;
	localparam logic [7:0] OFS_CTRL      = 8'h10;
	localparam int         ADDR_LSB      = 1;
	localparam int         RATE_MULTIPLIER_SEL_LSB      = 6;
	localparam int         XFER_START    = 8;
	localparam int         XFER_STOP     = 9;
	localparam int         CTRL_TEN_EN   = 0;
	localparam int         CTRL_HI_LSB   = 1;
	localparam logic [6:0] OWN_ADDR_RST  = 7'h00;
	localparam logic [1:0] RATE_MULTIPLIER_SEL_RST      = 2'h0;
	localparam logic [5:0] ICR_RST       = 6'h00;
	localparam logic [1:0] RATE_MULTIPLIER_SEL_X1       = 2'h0;
	localparam logic [1:0] RATE_MULTIPLIER_SEL_X2       = 2'h1;
	localparam logic [1:0] RATE_MULTIPLIER_SEL_X4       = 2'h2;
	localparam logic [4:0] TEN_BIT_HDR   = 5'h1E;

	// ************************************************************
	// bit slots of the engine
	// ************************************************************
	localparam logic [3:0] BIT_LAST_DATA = 4'h7;
	localparam logic [3:0] BIT_ACK       = 4'h8;
	localparam logic [3:0] BIT_STOP      = 4'h9;
	localparam logic [3:0] BIT_RESTART   = 4'hA;

	// ************************************************************
	// rate lookup, indexed by the clock rate code
	// ************************************************************
	localparam logic [5:0] ICR_GRP_B     = 6'h10;
	localparam logic [5:0] ICR_GRP_C     = 6'h18;
	localparam logic [5:0] ICR_GRP_D     = 6'h20;
	localparam logic [10:0] START_OFS_A  = 11'h004;
	localparam logic [10:0] START_OFS_B  = 11'h006;
	localparam logic [10:0] START_OFS_C  = 11'h002;
	localparam logic [10:0] STOP_OFS     = 11'h001;
	localparam logic [11:0] DIV_TAB [64] = '{
		12'h014, 12'h016, 12'h018, 12'h01A, 12'h01C, 12'h01E, 12'h022, 12'h028,
		12'h01C, 12'h020, 12'h024, 12'h028, 12'h02C, 12'h030, 12'h038, 12'h044,
		12'h030, 12'h038, 12'h040, 12'h048, 12'h050, 12'h058, 12'h068, 12'h080,
		12'h050, 12'h060, 12'h070, 12'h080, 12'h090, 12'h0A0, 12'h0C0, 12'h0F0,
		12'h0A0, 12'h0C0, 12'h0E0, 12'h100, 12'h120, 12'h140, 12'h180, 12'h1E0,
		12'h140, 12'h180, 12'h1C0, 12'h200, 12'h240, 12'h280, 12'h300, 12'h3C0,
		12'h280, 12'h300, 12'h380, 12'h400, 12'h480, 12'h500, 12'h600, 12'h780,
		12'h500, 12'h600, 12'h700, 12'h800, 12'h900, 12'hA00, 12'hC00, 12'hF00};
	localparam logic [9:0] SDA_TAB [64] = '{
		10'h007, 10'h007, 10'h008, 10'h008, 10'h009, 10'h009, 10'h00A, 10'h00A,
		10'h007, 10'h007, 10'h009, 10'h009, 10'h00B, 10'h00B, 10'h00D, 10'h00D,
		10'h009, 10'h009, 10'h00D, 10'h00D, 10'h011, 10'h011, 10'h015, 10'h015,
		10'h009, 10'h009, 10'h011, 10'h011, 10'h019, 10'h019, 10'h021, 10'h021,
		10'h011, 10'h011, 10'h021, 10'h021, 10'h031, 10'h031, 10'h041, 10'h041,
		10'h021, 10'h021, 10'h041, 10'h041, 10'h061, 10'h061, 10'h081, 10'h081,
		10'h041, 10'h041, 10'h081, 10'h081, 10'h0C1, 10'h0C1, 10'h101, 10'h101,
		10'h081, 10'h081, 10'h101, 10'h101, 10'h181, 10'h181, 10'h201, 10'h201};

	// ************************************************************
	// types
	// ************************************************************
	typedef struct packed {
		logic [13:0] period;
		logic [13:0] sda;
		logic [13:0] start;
		logic [13:0] stop;
	} rate_t;

	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_LOW, ST_HIGH, ST_STOP} eng_state_t;

	typedef struct packed {
		logic        waitreq;
		logic [31:0] rdata;
		logic [6:0]  own_addr;
		logic [1:0]  rate_multiplier_sel;
		logic [5:0]  clock_rate_code;
		logic        ten_en;
		logic [2:0]  hi_addr;
		eng_state_t  st;
		logic [13:0] cnt;
		logic [3:0]  bitn;
		logic [7:0]  shift;
		logic        stop_pend;
		logic        scl_oe_n;
		logic        sda_oe_n;
		logic        pin_lvl;
		logic        nack;
		logic        held;
		logic        busy;
	} main_state_t;

	typedef enum logic [1:0] {PH_FIRST, PH_SECOND, PH_DONE} match_phase_t;

	typedef struct packed {
		logic         scl_p;
		logic         sda_p;
		logic [7:0]   shift;
		logic [3:0]   nbit;
		match_phase_t phase;
		logic         match;
	} match_state_t;

endpackage

// ==== rtl/rate_lookup.sv ====
// clock rate code and multiplier to scaled bit period and hold counts
`timescale 1ns/10ps
module rate_lookup (
	input  wire logic [5:0]          i_code,
	input  wire logic [1:0]          i_rate_multiplier_sel,
	output i2c_rate_pkg::rate_t      o_tm
);
	logic [11:0] div;
	logic [10:0] half;
	logic [10:0] ofs;
	logic [1:0]  sh;

	always_comb begin
		div  = i2c_rate_pkg::DIV_TAB[i_code];
		half = div[11:1];
		if (i_code < i2c_rate_pkg::ICR_GRP_B) begin
			ofs = i2c_rate_pkg::START_OFS_A;
		end else if (i_code < i2c_rate_pkg::ICR_GRP_C) begin
			ofs = i2c_rate_pkg::START_OFS_B;
		end else begin
			ofs = i2c_rate_pkg::START_OFS_C;
		end
		// reserved multiplier code falls back to a factor of one
		unique case (i_rate_multiplier_sel)
			i2c_rate_pkg::RATE_MULTIPLIER_SEL_X2: sh = 2'h1;
			i2c_rate_pkg::RATE_MULTIPLIER_SEL_X4: sh = 2'h2;
			default:               sh = 2'h0;
		endcase
		o_tm.period = {2'h0, div} << sh;
		o_tm.sda    = {4'h0, i2c_rate_pkg::SDA_TAB[i_code]} << sh;
		o_tm.start  = {3'h0, half - ofs} << sh;
		o_tm.stop   = {3'h0, half + i2c_rate_pkg::STOP_OFS} << sh;
	end
endmodule // rate_lookup

// ==== rtl/addr_match.sv ====
// watches the bus for an address phase and compares it with the own address
`timescale 1ns/10ps
module addr_match (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_ce,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	input  wire logic [6:0] i_own_addr,
	input  wire logic       i_ten_en,
	input  wire logic [2:0] i_hi_addr,
	output logic            o_match
);
	localparam i2c_rate_pkg::match_state_t RST = '{
		scl_p: 1'b1, sda_p: 1'b1, shift: 8'h00, nbit: 4'h0,
		phase: i2c_rate_pkg::PH_DONE, match: 1'b0};

	i2c_rate_pkg::match_state_t q;
	i2c_rate_pkg::match_state_t d;
	logic [7:0]                 byte_now;

	always_comb begin
		d          = q;
		byte_now   = {q.shift[6:0], i_sda};
		d.scl_p    = i_scl;
		d.sda_p    = i_sda;
		if (q.scl_p && i_scl && q.sda_p && !i_sda) begin
			d.nbit  = 4'h0;
			d.phase = i2c_rate_pkg::PH_FIRST;
			d.match = 1'b0;
		end else if (!q.scl_p && i_scl && q.phase != i2c_rate_pkg::PH_DONE) begin
			d.shift = byte_now;
			d.nbit  = (q.nbit == i2c_rate_pkg::BIT_ACK) ? 4'h0 : q.nbit + 4'h1;
			if (q.nbit == i2c_rate_pkg::BIT_LAST_DATA) begin
				if (q.phase == i2c_rate_pkg::PH_SECOND) begin
					d.match = byte_now[7] == i_hi_addr[0] &&
						byte_now[6:0] == i_own_addr;
					d.phase = i2c_rate_pkg::PH_DONE;
				end else if (!i_ten_en) begin
					d.match = byte_now[7:1] == i_own_addr;
					d.phase = i2c_rate_pkg::PH_DONE;
				end else if (byte_now[7:3] == i2c_rate_pkg::TEN_BIT_HDR &&
					byte_now[2:1] == i_hi_addr[2:1]) begin
					d.phase = i2c_rate_pkg::PH_SECOND;
				end else begin
					d.phase = i2c_rate_pkg::PH_DONE;
				end
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q <= RST;
		end else if (i_ce) begin
			q <= d;
		end
	end

	assign o_match = q.match;
endmodule // addr_match

// ==== dv/rate_chk.sv ====
// port assertions for the address and rate block
`timescale 1ns/10ps
module rate_chk (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	input  wire logic [7:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [3:0]  i_byteenable,
	input  wire logic [31:0] o_readdata,
	input  wire logic        o_waitrequest,
	input  wire logic        o_scl,
	input  wire logic        o_scl_oe_n,
	input  wire logic        o_sda,
	input  wire logic        o_sda_oe_n,
	input  wire logic        o_busy
);
	// ****
	// helpers
	// ****
	logic req;
	assign req = (i_read | i_write) & o_waitrequest & i_ce;
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	sequence s_xfer_go;
		req & i_write & i_byteenable[0] & !o_busy & (i_address == 8'h08)
		##1 !o_waitrequest & i_ce;
	endsequence
	sequence s_odd_read;
		req & i_read & (i_address > 8'h10) ##1 !o_waitrequest;
	endsequence
	a_wait_one: assert property (req |=> !o_waitrequest)
		else $error("request not answered after one wait cycle");
	a_wait_pulse: assert property (!o_waitrequest && i_ce |=> o_waitrequest)
		else $error("waitrequest low too long");
	a_odd_zero: assert property (s_odd_read |-> o_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_xfer_busy: assert property (s_xfer_go |=> o_busy)
		else $error("transfer did not start");
	a_pins_open: assert property (o_scl == 1'h0 && o_sda == 1'h0)
		else $error("pin drive value not low");
	a_sda_hold: assert property ($fell(o_scl_oe_n) |-> $stable(o_sda_oe_n)[*6])
		else $error("sda changed too soon after scl fall");
	a_scl_low: assert property ($fell(o_scl_oe_n) |=> (!o_scl_oe_n)[*8])
		else $error("scl low phase too short");
	a_start_hold: assert property ($fell(o_sda_oe_n) && o_scl_oe_n |-> o_scl_oe_n[*6])
		else $error("start hold too short");
	a_stop_hold: assert property ($rose(o_sda_oe_n) && o_scl_oe_n |-> $past(o_scl_oe_n, 8))
		else $error("stop hold too short");
endmodule // rate_chk

bind i2c_address_and_rate_timing rate_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_ce(i_ce), .i_address(i_address), .i_read(i_read), .i_write(i_write),
	.i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
	.o_scl(o_scl), .o_scl_oe_n(o_scl_oe_n), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
	.o_busy(o_busy));

// ==== dv/bus_peer.sv ====
// other bus device: pulled-up wires, a slow slave and a small master
`timescale 1ns/10ps
module bus_peer (
	input  wire logic       i_clk,
	input  wire logic       i_scl_oe_n,
	input  wire logic       i_sda_oe_n,
	input  wire logic [3:0] i_stretch,
	output logic            o_scl,
	output logic            o_sda
);
	// ****
	// wires and stretching
	// ****
	logic [3:0] hold_q = 4'h0;
	logic       mscl_q = 1'h0;
	logic       msda_q = 1'h0;
	// pull-ups: a released line reads high
	assign o_scl = i_scl_oe_n & (hold_q == 4'h0) & !mscl_q;
	assign o_sda = i_sda_oe_n & !msda_q;
	// slow slave keeps scl low a few cycles after each release
	always @(posedge i_clk) begin
		if (!i_scl_oe_n)
			hold_q <= i_stretch;
		else if (hold_q != 4'h0)
			hold_q <= hold_q - 4'h1;
	end
	task automatic step(input logic c, input logic d);
		repeat (20) @(posedge i_clk);
		mscl_q <= c;
		msda_q <= d;
	endtask
	// sda moves only while scl is low, so no false start or stop
	task automatic put(input logic d);
		step(1'h1, msda_q);
		step(1'h1, d);
		step(1'h0, d);
	endtask
	task automatic frame(input logic [15:0] w, input int n);
		int i;
		step(1'h0, 1'h1);
		for (i = 8 * n - 1; i >= 0; i--) begin
			put(!w[i]);
			if (i % 8 == 0)
				put(1'h0);
		end
		put(1'h1);
		step(1'h0, 1'h0);
	endtask
endmodule // bus_peer

// ==== dv/testbench.sv ====
// self-checking bench for the address and rate block
`timescale 1ns/10ps
module testbench;
	// ****
	// signals and tables
	// ****
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic [7:0]  adr = 8'h00;
	logic        rd = 1'h0;
	logic        wr = 1'h0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  be = 4'hF;
	logic [3:0]  stretch = 4'h0;
	logic [31:0] rdata;
	logic        wreq;
	logic        scl;
	logic        sda;
	logic        scl_oe_n;
	logic        sda_oe_n;
	logic        busy;
	logic        match;
	logic [2:0]  sig;
	logic [31:0] q;
	int          bad_count = 0;
	int          total_checks = 0;
	int          n;
	int          t;
	int          dv[33] = '{20, 22, 24, 26, 28, 30, 34, 40, 28, 32, 36, 40, 44, 48, 56, 68, 48,
		56, 64, 72, 80, 88, 104, 128, 80, 96, 112, 128, 144, 160, 192, 240, 160};
	int          sh[33] = '{7, 7, 8, 8, 9, 9, 10, 10, 7, 7, 9, 9, 11, 11, 13, 13, 9, 9, 13,
		13, 17, 17, 21, 21, 9, 9, 17, 17, 25, 25, 33, 33, 17};
	logic [7:0]  cs[6] = '{8'h00, 8'h4F, 8'h97, 8'hD8, 8'h1F, 8'h20};
	assign sig = {busy, sda_oe_n, scl_oe_n};
	i2c_address_and_rate_timing u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'h1),
		.i_address(adr), .i_read(rd), .i_write(wr), .i_writedata(wdata), .i_byteenable(be),
		.o_readdata(rdata), .o_waitrequest(wreq), .i_scl(scl), .o_scl(), .o_scl_oe_n(scl_oe_n),
		.i_sda(sda), .o_sda(), .o_sda_oe_n(sda_oe_n), .o_busy(busy), .o_addr_match(match));
	bus_peer u_peer (.i_clk(clk), .i_scl_oe_n(scl_oe_n), .i_sda_oe_n(sda_oe_n),
		.i_stretch(stretch), .o_scl(scl), .o_sda(sda));
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic finish_test;
		if (bad_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: got %0h, expected %0h", $time, got, exp);
		end
	endtask
	task automatic fail_out;
		bad_count++;
		$display("ERROR %0t: wait ran out", $time);
		finish_test();
	endtask
	// request held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] e);
		int k;
		rd <= !w;
		wr <= w;
		adr <= a;
		wdata <= d;
		be <= e;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (wreq !== 1'h0 && k < 50);
		q = rdata;
		rd <= 1'h0;
		wr <= 1'h0;
		@(posedge clk);
		if (k >= 50)
			fail_out();
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0000_0000, 4'hF);
		check(q, e);
	endtask
	// counts edges until the chosen line settles; #1 lets edge updates land
	task automatic wait_oe(input int s, input logic v);
		#1;
		n = 0;
		while (sig[s] !== v) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 9000)
				fail_out();
		end
	endtask
	// byte 0xFF keeps sda released in every high phase except the stop
	task automatic timing(input logic [7:0] rc, input logic [3:0] s);
		int mul;
		int d;
		int p;
		int i;
		mul = rc[7:6] == 2'h2 ? 4 : rc[7:6] == 2'h1 ? 2 : 1;
		d = dv[rc[5:0]];
		p = d * mul;
		stretch <= s;
		bus(1'h1, 8'h04, {24'h00_0000, rc}, 4'hF);
		bus(1'h1, 8'h08, 32'h0000_03FF, 4'hF);
		wait_oe(1, 1'h0);
		wait_oe(0, 1'h0);
		check(n, (d / 2 - (rc[5:0] < 6'h10 ? 4 : rc[5:0] < 6'h18 ? 6 : 2)) * mul);
		wait_oe(1, 1'h1);
		check(n, sh[rc[5:0]] * mul);
		t = n;
		wait_oe(0, 1'h1);
		check(n + t, p / 2);
		wait_oe(0, 1'h0);
		check(n, s + p - p / 2);
		i = 0;
		do begin
			wait_oe(0, 1'h0);
			wait_oe(0, 1'h1);
			i++;
		end while (sda_oe_n && i < 12);
		wait_oe(1, 1'h1);
		check(n, s + (d / 2 + 1) * mul);
		wait_oe(2, 1'h0);
		// back on an edge so the next request rises right after it
		@(posedge clk);
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		int i;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		for (i = 0; i < 6; i++)
			rchk(8'(4 * i), 32'h0000_0000);
		bus(1'h1, 8'h00, 32'h0000_00A5, 4'hF);
		rchk(8'h00, 32'h0000_00A4);
		bus(1'h1, 8'h00, 32'h0000_00FF, 4'hE);
		rchk(8'h00, 32'h0000_00A4);
		bus(1'h1, 8'h14, 32'h0000_00FF, 4'hF);
		rchk(8'h14, 32'h0000_0000);
		bus(1'h1, 8'h04, 32'hFFFF_FFD5, 4'hF);
		rchk(8'h04, 32'h0000_00D5);
		for (i = 0; i < 6; i++)
			timing(cs[i], 4'(i % 3));
		u_peer.frame(16'h00A4, 1);
		check(match, 1'h1);
		u_peer.frame(16'h00A2, 1);
		check(match, 1'h0);
		bus(1'h1, 8'h10, 32'h0000_000B, 4'hF);
		u_peer.frame(16'hF4D2, 2);
		check(match, 1'h1);
		u_peer.frame(16'hF452, 2);
		check(match, 1'h0);
		// a byte without stop keeps scl low; a start flag then repeats the start
		stretch <= 4'h0;
		bus(1'h1, 8'h04, 32'h0000_0000, 4'hF);
		bus(1'h1, 8'h08, 32'h0000_0155, 4'hF);
		wait_oe(2, 1'h0);
		check(sig, 32'h0000_0002);
		@(posedge clk);
		rchk(8'h0C, 32'h0000_000A);
		bus(1'h1, 8'h08, 32'h0000_03FF, 4'hF);
		wait_oe(1, 1'h0);
		wait_oe(0, 1'h0);
		check(n, dv[0] / 2 - 4);
		wait_oe(2, 1'h0);
		@(posedge clk);
		rchk(8'h0C, 32'h0000_0002);
		finish_test();
	end
endmodule // testbench
